// ---- core/ddw_defines.vh ----
// Summary of operation
// - reset loads control register with FEh
// - soft reset bit cleared resets chip
// - register period bits reversed versus counter
// - 64 periods, 3072 to 196608 cycles
// - hardware activation forces activation bit high
// - software activation sticks until reset
// - inactive counter resets chip too, without guard
// - at least 28 instructions before active counter expiry resets chip
// - active counter clearing soft reset bit resets chip
// - hardware activation without gating: stop waits
// - gated stop with NMI high freezes counter
// - wake from stop resumes countdown
`ifndef DDW_DEFINES_VH
`define DDW_DEFINES_VH
`define DDW_ADDR_CTRL    8'hD8
`define DDW_RESET_VALUE  8'hFE
`define DDW_BIT_ACT      0
`define DDW_BIT_SR       1
`define DDW_PRESCALE     3072
`define DDW_PRESCALE_W   12
`define DDW_GUARD_INSTR  28
`endif

// ---- core/ddw_prescaler.v ----
`timescale 1ns/1ps
`include "ddw_defines.vh"
module ddw_prescaler #(
  parameter DIV   = `DDW_PRESCALE,
  parameter WIDTH = `DDW_PRESCALE_W
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_clear,
  input  wire i_run,
  output reg  o_tick
);
  reg [WIDTH-1:0] cnt_r;
  always @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      cnt_r  <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else if (i_run) begin
      if (cnt_r == DIV[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        cnt_r  <= {WIDTH{1'b0}};
        o_tick <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        o_tick <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end
endmodule

// ---- core/ddw_watchdog.v ----
`timescale 1ns/1ps
`include "ddw_defines.vh"
module ddw_watchdog #(
  parameter PRESCALE = `DDW_PRESCALE,
  parameter GUARD    = `DDW_GUARD_INSTR
) (
  input  wire       I_REF_CLK,
  input  wire       I_RST_N,
  input  wire       i_hw_activation,
  input  wire       i_stop_gating,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire       i_instr_done,
  input  wire       i_stop_instr,
  input  wire       i_wake,
  input  wire       i_nmi_pin,
  output reg  [7:0] o_rdata,
  output reg        o_sys_reset,
  output reg        o_stop_mode,
  output reg        o_wait_mode,
  output reg        o_active
);
  // register image, physical order: cnt[6]=soft reset bit, cnt[5:0]=period
  reg  [6:0] cnt_r;
  reg  [6:0] cnt_nxt;
  reg        act_r;
  reg        act_nxt;
  reg        frozen_r;
  reg  [5:0] guard_r;
  reg        armed_r;
  reg        hw_opt_r;
  wire       sel_wr;
  wire       tick;
  wire       trigger;
  reg  [5:0] guard_nxt;
  reg        armed_nxt;
  reg        frozen_nxt;
  reg        sys_reset_nxt;
  reg        stop_mode_nxt;
  reg        wait_mode_nxt;
  reg  [7:0] rdata_nxt;
  wire       sel_rd;

  // reversed bit order between register and counter
  function [6:0] reg_to_cnt;
    input [7:0] v;
    begin
      reg_to_cnt = {v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    end
  endfunction

  function [7:0] cnt_to_reg;
    input [6:0] c;
    input       a;
    begin
      cnt_to_reg = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
    end
  endfunction

  // single register decode shared by both strobes
  function is_ctrl;
    input [7:0] addr;
    begin
      is_ctrl = (addr == `DDW_ADDR_CTRL);
    end
  endfunction

  assign sel_wr = i_wr && is_ctrl(i_addr);
  assign sel_rd = i_rd && is_ctrl(i_addr);

  ddw_prescaler #(
    .DIV   (PRESCALE),
    .WIDTH (`DDW_PRESCALE_W)
  ) u_pre (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_clear (sel_wr),
    .i_run   (!frozen_r),
    .o_tick  (tick)
  );

  always @* begin
    cnt_nxt = cnt_r;
    act_nxt = act_r | hw_opt_r;
    if (sel_wr) begin
      cnt_nxt = reg_to_cnt(i_wdata);
      act_nxt = act_r | hw_opt_r | i_wdata[`DDW_BIT_ACT];
    end else if (tick) begin
      cnt_nxt = cnt_r - 7'h01;
    end
  end

  assign trigger = !cnt_nxt[6] && (armed_r || !act_r);

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      hw_opt_r <= 1'b0;
    end else begin
      hw_opt_r <= i_hw_activation;
    end
  end

  always @* begin
    guard_nxt = guard_r;
    armed_nxt = armed_r;
    // guard idle until activation
    if (!act_r) begin
      guard_nxt = 6'h00;
      armed_nxt = 1'b0;
    end else if (!armed_r && i_instr_done) begin
      guard_nxt = guard_r + 6'h01;
      if (guard_r == GUARD[5:0] - 6'h01) begin
        armed_nxt = 1'b1;
      end
    end
  end

  // write clearing soft reset bit always resets at once
  always @* begin
    if (sel_wr && !i_wdata[`DDW_BIT_SR]) begin
      sys_reset_nxt = 1'b1;
    end else if (act_r && !armed_r) begin
      // expiry hidden during the guard window
      sys_reset_nxt = 1'b0;
    end else begin
      sys_reset_nxt = trigger;
    end
  end

  // idle state, stop gating and NMI decide stop vs wait
  always @* begin
    frozen_nxt    = frozen_r;
    stop_mode_nxt = o_stop_mode;
    wait_mode_nxt = o_wait_mode;
    // stop outranks a wake in the same cycle
    if (i_stop_instr) begin
      if (!act_r && !hw_opt_r) begin
        // idle watchdog: true stop allowed
        frozen_nxt    = 1'b1;
        stop_mode_nxt = 1'b1;
      end else if (i_stop_gating && i_nmi_pin) begin
        frozen_nxt    = 1'b1;
        stop_mode_nxt = 1'b1;
      end else begin
        wait_mode_nxt = 1'b1;
      end
    end else if (i_wake) begin
      frozen_nxt    = 1'b0;
      stop_mode_nxt = 1'b0;
      wait_mode_nxt = 1'b0;
    end
  end

  // registered image, holds until next read
  always @* begin
    rdata_nxt = o_rdata;
    if (sel_rd) begin
      rdata_nxt = cnt_to_reg(cnt_r, act_r | hw_opt_r);
    end
  end

  // write reload and prescaled decrement
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      cnt_r <= reg_to_cnt(`DDW_RESET_VALUE);
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      guard_r <= 6'h00;
      armed_r <= 1'b0;
    end else begin
      guard_r <= guard_nxt;
      armed_r <= armed_nxt;
    end
  end

  // frozen counter also holds its prescaler phase
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      frozen_r <= 1'b0;
    end else begin
      frozen_r <= frozen_nxt;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      o_sys_reset <= 1'b0;
    end else begin
      o_sys_reset <= sys_reset_nxt;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      o_stop_mode <= 1'b0;
      o_wait_mode <= 1'b0;
      o_active    <= 1'b0;
    end else begin
      o_stop_mode <= stop_mode_nxt;
      o_wait_mode <= wait_mode_nxt;
      o_active    <= act_nxt;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end
endmodule

// ---- testbench/ddw_watchdog_assertions.sv ----
`timescale 1ns/1ps
module ddw_chk(input I_REF_CLK, I_RST_N, i_hw_activation, i_stop_gating, i_wr,
  input i_stop_instr, i_wake, i_nmi_pin, o_sys_reset, o_stop_mode, o_wait_mode, o_active,
  input [7:0] i_addr, i_wdata);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  wire st = i_stop_instr & o_active;
  chk_sr_clear: assert property (i_wr && i_addr == 8'hD8 && !i_wdata[1] |=> o_sys_reset)
    else $error("soft reset missed");
  chk_hw_active: assert property (i_hw_activation && $past(I_RST_N) |=> o_active)
    else $error("hw activation lost");
  chk_stays_on: assert property (o_active |=> o_active)
    else $error("watchdog turned off");
  chk_out_idle: assert property ($rose(I_RST_N) |-> !o_sys_reset && !o_active)
    else $error("outputs not idle");
  chk_wait_hw: assert property (st && !i_stop_gating |=> o_wait_mode && !o_stop_mode)
    else $error("stop not wait");
  chk_stop_gate: assert property (st && i_stop_gating && i_nmi_pin |=> o_stop_mode)
    else $error("stop missed");
  chk_nmi_low: assert property (st && i_stop_gating && !i_nmi_pin |=> o_wait_mode)
    else $error("nmi low not wait");
  chk_wake_run: assert property (i_wake && !i_stop_instr |=> !o_stop_mode && !o_wait_mode)
    else $error("wake ignored");
endmodule
bind ddw_watchdog ddw_chk u_chk(.*);

// ---- testbench/digital_downcount_watchdog_test.sv ----
`timescale 1ns/1ps
module digital_downcount_watchdog_test;
  reg clk = 0, rst_n = 0, hw = 0, gat = 0, wr = 0, rd = 0, idn = 0, stp = 0, wk = 0, nmi = 0;
  reg [7:0] a = 8'hD8, wd = 8'h00;
  wire [7:0] rdt;
  wire sr, sm, wm, act;
  integer mismatches = 0, n_tests = 0, i;
  always #25 clk = ~clk;
  ddw_watchdog #(.PRESCALE(4)) DUT(.I_REF_CLK(clk), .I_RST_N(rst_n), .i_hw_activation(hw),
    .i_stop_gating(gat), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_instr_done(idn),
    .i_stop_instr(stp), .i_wake(wk), .i_nmi_pin(nmi), .o_rdata(rdt), .o_sys_reset(sr),
    .o_stop_mode(sm), .o_wait_mode(wm), .o_active(act));
  task cyc(input integer n); repeat (n) @(negedge clk); endtask
  task chk(input [7:0] g, e); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task wr8(input [7:0] v); begin wd = v; wr = 1; cyc(1); wr = 0; end endtask
  task rd8(input [7:0] e); begin rd = 1; cyc(1); rd = 0; cyc(1); chk(rdt, e); end endtask
  task stop(input n); begin nmi = n; stp = 1; cyc(1); stp = 0; cyc(1); end endtask
  task wake; begin wk = 1; cyc(1); wk = 0; cyc(1); end endtask
  task rst(input h); begin hw = h; rst_n = 0; cyc(4); rst_n = 1; cyc(2); end endtask
  task wt1; begin
    i = 0;
    while (sr !== 1'b1 && i < 40) begin cyc(1); i = i + 1; end
    chk(sr, 1);
  end endtask
  task end_sim; begin
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end endtask
  initial begin #200000; mismatches = mismatches + 1; end_sim; end
  initial begin
    rst(0);
    a = 8'hD9; wr8(8'h00); a = 8'hD8;
    rd8(8'hFE);
    wr8(8'h82);
    rd8(8'h82);
    cyc(3);
    rd8(8'h02);
    wt1;
    $display("timer done");
    rst(0);
    wr8(8'hFD);
    chk(sr, 1);
    $display("soft reset done");
    rst(0);
    wr8(8'hFF);
    cyc(2);
    chk(act, 1);
    wr8(8'hFE);
    rd8(8'hFF);
    gat = 1;
    stop(1);
    chk(sm, 1);
    wake;
    chk(sm, 0);
    stop(0);
    chk(wm, 1);
    wake;
    wr8(8'h83);
    cyc(20);
    chk(sr, 0);
    repeat (28) begin idn = 1; cyc(1); idn = 0; cyc(1); end
    wr8(8'h83);
    wt1;
    $display("software mode done");
    gat = 0;
    rst(1);
    rd8(8'hFF);
    wr8(8'hFE);
    rd8(8'hFF);
    stop(1);
    chk(wm, 1);
    wake;
    gat = 1;
    stop(1);
    chk(sm, 1);
    wake;
    chk(sm, 0);
    $display("hardware mode done");
    end_sim;
  end
endmodule
